// ===== design/sbsrt_burst_seq.sv
`timescale 1ns/1ps
module sbsrt_burst_seq (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic [6:0] push_addr,
	input wire logic [3:0] tap,
	input wire logic burst8,
	output logic beat_v,
	output logic [6:0] beat_addr
);
	logic [sbsrt_pkg::PIPE_DEPTH-1:0] v_reg;
	logic [6:0] a_reg [sbsrt_pkg::PIPE_DEPTH];
	logic [1:0] left_reg;
	logic [6:0] next_reg;
	logic tap_v;

	// Column order wraps inside the burst, bank bits never move
	function automatic logic [6:0] wrap_next(input logic [6:0] a, input logic long);
		logic [6:0] r;
		r = a;
		if (long)
			r[1:0] = a[1:0] + 2'h1;
		else
			r[0] = ~a[0];
		return r;
	endfunction : wrap_next

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			v_reg <= '0;
			for (int i = 0; i < sbsrt_pkg::PIPE_DEPTH; i++)
				a_reg[i] <= 7'h00;
		end
		else
		begin
			v_reg <= {v_reg[sbsrt_pkg::PIPE_DEPTH-2:0], push};
			a_reg[0] <= push_addr;
			for (int i = 1; i < sbsrt_pkg::PIPE_DEPTH; i++)
				a_reg[i] <= a_reg[i-1];
		end
	end

	assign tap_v = v_reg[tap];
	assign beat_v = tap_v || (left_reg != 2'h0);
	// A burst leaving the pipe takes over from one still running
	assign beat_addr = tap_v ? a_reg[tap] : next_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			left_reg <= 2'h0;
			next_reg <= 7'h00;
		end
		else
		begin
			if (tap_v)
				left_reg <= burst8 ? sbsrt_pkg::BEATS_LONG : sbsrt_pkg::BEATS_SHORT;
			else if (left_reg != 2'h0)
				left_reg <= left_reg - 2'h1;
			next_reg <= wrap_next(beat_addr, burst8);
		end
	end
endmodule : sbsrt_burst_seq

// ===== design/sbsrt_pkg.sv
package sbsrt_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_ERROR = 4'h8;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0;

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	localparam int CFG_BURST8_BIT = 0;
	localparam int CFG_CAL_LSB = 1;
	localparam int CFG_ADL_LSB = 4;
	localparam logic [6:0] CFG_RESET = 7'h26;
	localparam logic [2:0] CAL_MIN = 3'h2;
	localparam logic [2:0] CAL_MAX = 3'h6;
	localparam logic [2:0] ADL_MAX = 3'h5;

	// ----------------------------------------
	// Status fields
	// ----------------------------------------
	localparam int ST_BANKS_LSB = 0;
	localparam int ST_RDLAT_LSB = 8;
	localparam int ST_WRLAT_LSB = 12;
	localparam int ST_SELFREF_BIT = 16;
	localparam int ST_RD_HOLD_BIT = 17;
	localparam int ST_CMD_HOLD_BIT = 18;

	// ----------------------------------------
	// Error flags (sticky, write one to clear)
	// ----------------------------------------
	localparam int ERR_IDLE_BANK = 0;
	localparam int ERR_SR_OPEN = 1;
	localparam int ERR_SR_TERM = 2;
	localparam int ERR_TERM_EARLY = 3;
	localparam int ERR_RD_EARLY = 4;
	localparam int ERR_CMD_EARLY = 5;
	localparam int ERR_W = 6;

	// ----------------------------------------
	// Latency pipeline and data store
	// ----------------------------------------
	localparam int PIPE_DEPTH = 10;
	localparam logic [3:0] TAP_MAX = 4'h9;
	localparam logic [3:0] PIPE_OFFSET = 4'h2;
	localparam logic [1:0] BEATS_SHORT = 2'h1;
	localparam logic [1:0] BEATS_LONG = 2'h3;
	localparam int MEM_WORDS = 128;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int TERM_OFF_CLK = 3;
	localparam int SELFREF_EXIT_TO_READ_CLK = 200;
	localparam int SELFREF_EXIT_TO_OTHER_NS = 200;
	localparam int SELFREF_EXIT_TO_OTHER_CYC =
		(SELFREF_EXIT_TO_OTHER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Commands {row strobe, column strobe, write enable}
	// ----------------------------------------
	typedef enum logic [2:0] {
		CMD_MODE = 3'b000,
		CMD_REFRESH = 3'b001,
		CMD_PRECHARGE = 3'b010,
		CMD_ACTIVATE = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_READ = 3'b101,
		CMD_STOP = 3'b110,
		CMD_NOP = 3'b111
	} sbsrt_cmd_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_SELFREF = 2'b01
	} sbsrt_pwr_t;
endpackage : sbsrt_pkg

// ===== design/sbsrt_sr_guard.sv
`timescale 1ns/1ps
module sbsrt_sr_guard (
	input wire logic clk,
	input wire logic rst,
	input wire logic sr_entry,
	input wire logic sr_exit,
	input wire logic cmd_rd,
	input wire logic cmd_other,
	input wire logic term_en,
	input wire logic banks_idle,
	output logic rd_hold,
	output logic cmd_hold,
	output logic [sbsrt_pkg::ERR_W-1:0] err
);
	logic [7:0] off_cnt_reg;
	logic [7:0] exit_cnt_reg;
	logic exiting_reg;

	// Counts how long termination has been off, saturating
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			off_cnt_reg <= 8'h00;
		else if (term_en)
			off_cnt_reg <= 8'h00;
		else if (off_cnt_reg < 8'(sbsrt_pkg::TERM_OFF_CLK))
			off_cnt_reg <= off_cnt_reg + 8'h01;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			exiting_reg <= 1'b0;
			exit_cnt_reg <= 8'h00;
		end
		else if (sr_exit)
		begin
			exiting_reg <= 1'b1;
			exit_cnt_reg <= 8'h01;
		end
		else if (exiting_reg)
		begin
			exit_cnt_reg <= exit_cnt_reg + 8'h01;
			if (exit_cnt_reg == 8'(sbsrt_pkg::SELFREF_EXIT_TO_READ_CLK - 1))
				exiting_reg <= 1'b0;
		end
	end

	assign rd_hold = sr_exit || exiting_reg;
	assign cmd_hold = sr_exit ||
		(exiting_reg && exit_cnt_reg < 8'(sbsrt_pkg::SELFREF_EXIT_TO_OTHER_CYC));

	always_comb
	begin
		err = '0;
		err[sbsrt_pkg::ERR_SR_OPEN] = sr_entry && !banks_idle;
		err[sbsrt_pkg::ERR_SR_TERM] = sr_entry &&
			(term_en || off_cnt_reg < 8'(sbsrt_pkg::TERM_OFF_CLK));
		err[sbsrt_pkg::ERR_TERM_EARLY] = rd_hold && term_en;
		err[sbsrt_pkg::ERR_RD_EARLY] = rd_hold && cmd_rd;
		err[sbsrt_pkg::ERR_CMD_EARLY] = cmd_hold && cmd_other;
	end
endmodule : sbsrt_sr_guard

// ===== design/sbsrt_top.sv
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Reads every 2 clocks (4-beat) or 4 clocks (8-beat) give gapless data.
// - Gapless bursts may hit any bank, but only activated banks.
// - Writes every 2 clocks (4-beat) or 4 clocks (8-beat) take data continuously.
// - Write latency is one clock less than read latency.
// - Read latency is additive latency plus column access latency.
module sbsrt_top (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [3:0] AV_ADDRESS,
	input wire logic AV_READ,
	input wire logic AV_WRITE,
	input wire logic [31:0] AV_WRITEDATA,
	input wire logic [3:0] AV_BYTEENABLE,
	output logic [31:0] AV_READDATA,
	output logic AV_WAITREQUEST,
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [2:0] BA,
	input wire logic [12:0] ADDR,
	input wire logic TERMINATION_ENABLE,
	input wire logic [31:0] DQ_IN,
	output logic [31:0] DQ_OUT,
	output logic DQ_OE,
	output logic TERM_ACTIVE,
	output logic SELFREF_ACTIVE
);
	sbsrt_pkg::sbsrt_pwr_t pwr_reg;
	sbsrt_pkg::sbsrt_cmd_t cmd;
	logic cke_prev_reg;
	logic [6:0] cfg_reg;
	logic [3:0] read_latency_reg;
	logic [3:0] tap_reg;
	logic [7:0] bank_reg;
	logic [sbsrt_pkg::ERR_W-1:0] err_reg;
	logic [31:0] mem_reg [sbsrt_pkg::MEM_WORDS];
	logic live, sr_entry, sr_exit, is_rd, is_wr, bank_ok;
	logic rd_push, wr_push, cmd_other, burst8;
	logic rd_beat_v, wr_beat_v, rd_hold, cmd_hold;
	logic [6:0] rd_beat_addr, wr_beat_addr;
	logic [sbsrt_pkg::ERR_W-1:0] guard_err, err_set;
	logic av_req, cfg_wr, err_wr;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign cmd = sbsrt_pkg::sbsrt_cmd_t'({RAS_N, CAS_N, WE_N});
	assign live = (pwr_reg == sbsrt_pkg::PWR_ACTIVE) && CKE && cke_prev_reg && !CS_N;
	assign sr_entry = (pwr_reg == sbsrt_pkg::PWR_ACTIVE) && cke_prev_reg && !CKE &&
		!CS_N && (cmd == sbsrt_pkg::CMD_REFRESH);
	assign sr_exit = (pwr_reg == sbsrt_pkg::PWR_SELFREF) && CKE;
	assign is_rd = live && (cmd == sbsrt_pkg::CMD_READ);
	assign is_wr = live && (cmd == sbsrt_pkg::CMD_WRITE);
	assign cmd_other = live && (cmd != sbsrt_pkg::CMD_NOP) && (cmd != sbsrt_pkg::CMD_READ);
	assign bank_ok = bank_reg[BA];
	// Column commands to a closed bank carry no data at all
	assign rd_push = is_rd && bank_ok;
	assign wr_push = is_wr && bank_ok;
	assign burst8 = cfg_reg[sbsrt_pkg::CFG_BURST8_BIT];

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			cke_prev_reg <= 1'b0;
		else
			cke_prev_reg <= CKE;
	end

	// ----------------------------------------
	// Power state
	// ----------------------------------------
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			pwr_reg <= sbsrt_pkg::PWR_ACTIVE;
		else
		begin
			case (pwr_reg)
				sbsrt_pkg::PWR_ACTIVE:
					if (sr_entry)
						pwr_reg <= sbsrt_pkg::PWR_SELFREF;
				sbsrt_pkg::PWR_SELFREF:
					if (sr_exit)
						pwr_reg <= sbsrt_pkg::PWR_ACTIVE;
				default:
					pwr_reg <= sbsrt_pkg::PWR_ACTIVE;
			endcase
		end
	end

	// ----------------------------------------
	// Bank bookkeeping
	// ----------------------------------------
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			bank_reg <= 8'h00;
		else if (live)
		begin
			case (cmd)
				sbsrt_pkg::CMD_ACTIVATE:
					bank_reg[BA] <= 1'b1;
				sbsrt_pkg::CMD_PRECHARGE:
					if (ADDR[10])
						bank_reg <= 8'h00;
					else
						bank_reg[BA] <= 1'b0;
				sbsrt_pkg::CMD_READ, sbsrt_pkg::CMD_WRITE:
					if (ADDR[10] && bank_ok)
						bank_reg[BA] <= 1'b0;
				default:
					bank_reg <= bank_reg;
			endcase
		end
	end

	// ----------------------------------------
	// Latency
	// ----------------------------------------
	// The pipe tap sits two clocks short of the read latency: one clock to load the pipe
	// and one for the output flop. Writes sample the pin one clock earlier at the same tap.
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			read_latency_reg <= 4'h0;
			tap_reg <= 4'h0;
		end
		else
		begin
			read_latency_reg <= 4'(cfg_reg[6:4]) + 4'(cfg_reg[3:1]);
			tap_reg <= 4'(cfg_reg[6:4]) + 4'(cfg_reg[3:1]) - sbsrt_pkg::PIPE_OFFSET;
		end
	end

	// ----------------------------------------
	// Burst engines
	// ----------------------------------------
	sbsrt_burst_seq u_rd_seq (
		.clk(MCLK),
		.rst(RST),
		.push(rd_push),
		.push_addr({BA, ADDR[3:0]}),
		.tap(tap_reg),
		.burst8(burst8),
		.beat_v(rd_beat_v),
		.beat_addr(rd_beat_addr)
	);

	sbsrt_burst_seq u_wr_seq (
		.clk(MCLK),
		.rst(RST),
		.push(wr_push),
		.push_addr({BA, ADDR[3:0]}),
		.tap(tap_reg),
		.burst8(burst8),
		.beat_v(wr_beat_v),
		.beat_addr(wr_beat_addr)
	);

	// Back-to-back bursts chain in the engines with no idle clock
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			DQ_OUT <= 32'h0;
			DQ_OE <= 1'b0;
		end
		else
		begin
			DQ_OE <= rd_beat_v;
			DQ_OUT <= rd_beat_v ? mem_reg[rd_beat_addr] : 32'h0;
		end
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 0; i < sbsrt_pkg::MEM_WORDS; i++)
				mem_reg[i] <= 32'h0;
		end
		else if (wr_beat_v)
			mem_reg[wr_beat_addr] <= DQ_IN;
	end

	// ----------------------------------------
	// Self-refresh checks and termination
	// ----------------------------------------
	sbsrt_sr_guard u_guard (
		.clk(MCLK),
		.rst(RST),
		.sr_entry(sr_entry),
		.sr_exit(sr_exit),
		.cmd_rd(is_rd),
		.cmd_other(cmd_other),
		.term_en(TERMINATION_ENABLE),
		.banks_idle(bank_reg == 8'h00),
		.rd_hold(rd_hold),
		.cmd_hold(cmd_hold),
		.err(guard_err)
	);

	// Termination stays off from the second clock of self-refresh on, whatever the pin says
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			TERM_ACTIVE <= 1'b0;
			SELFREF_ACTIVE <= 1'b0;
		end
		else
		begin
			TERM_ACTIVE <= TERMINATION_ENABLE && (pwr_reg != sbsrt_pkg::PWR_SELFREF);
			SELFREF_ACTIVE <= (pwr_reg == sbsrt_pkg::PWR_SELFREF) || sr_entry;
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	assign av_req = AV_READ || AV_WRITE;
	assign cfg_wr = AV_WRITE && !AV_WAITREQUEST && (AV_ADDRESS == sbsrt_pkg::ADDR_CONFIG) &&
		AV_BYTEENABLE[0];
	assign err_wr = AV_WRITE && !AV_WAITREQUEST && (AV_ADDRESS == sbsrt_pkg::ADDR_ERROR) &&
		AV_BYTEENABLE[0];

	always_comb
	begin
		err_set = guard_err;
		err_set[sbsrt_pkg::ERR_IDLE_BANK] = (is_rd || is_wr) && !bank_ok;
		case (AV_ADDRESS)
			sbsrt_pkg::ADDR_CONFIG:
				rd_mux = {25'h0, cfg_reg};
			sbsrt_pkg::ADDR_STATUS:
				rd_mux = {13'h0, cmd_hold, rd_hold, (pwr_reg == sbsrt_pkg::PWR_SELFREF),
					read_latency_reg - 4'h1, read_latency_reg, bank_reg};
			sbsrt_pkg::ADDR_ERROR:
				rd_mux = {26'h0, err_reg};
			default:
				rd_mux = sbsrt_pkg::UNMAPPED_DATA;
		endcase
	end

	// One wait clock per access; read data is latched while waitrequest is still high
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			AV_WAITREQUEST <= 1'b1;
			AV_READDATA <= 32'h0;
		end
		else if (av_req && AV_WAITREQUEST)
		begin
			AV_WAITREQUEST <= 1'b0;
			AV_READDATA <= rd_mux;
		end
		else
			AV_WAITREQUEST <= 1'b1;
	end

	// Out-of-range latencies are pulled back so the pipe tap stays inside the pipe
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			cfg_reg <= sbsrt_pkg::CFG_RESET;
		else if (cfg_wr)
		begin
			cfg_reg[0] <= AV_WRITEDATA[sbsrt_pkg::CFG_BURST8_BIT];
			if (AV_WRITEDATA[3:1] < sbsrt_pkg::CAL_MIN)
				cfg_reg[3:1] <= sbsrt_pkg::CAL_MIN;
			else if (AV_WRITEDATA[3:1] > sbsrt_pkg::CAL_MAX)
				cfg_reg[3:1] <= sbsrt_pkg::CAL_MAX;
			else
				cfg_reg[3:1] <= AV_WRITEDATA[3:1];
			if (AV_WRITEDATA[6:4] > sbsrt_pkg::ADL_MAX)
				cfg_reg[6:4] <= sbsrt_pkg::ADL_MAX;
			else
				cfg_reg[6:4] <= AV_WRITEDATA[6:4];
		end
	end

	// A new event beats a simultaneous clear
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			err_reg <= '0;
		else if (err_wr)
			err_reg <= (err_reg & ~AV_WRITEDATA[sbsrt_pkg::ERR_W-1:0]) | err_set;
		else
			err_reg <= err_reg | err_set;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	rd_latency_a: assert property (
		(rd_push && read_latency_reg == 4'h5 && $stable(read_latency_reg)) |-> ##5 DQ_OE)
		else $error("read data not five clocks after read");

	wr_latency_a: assert property (
		(wr_push && read_latency_reg == 4'h5 && $stable(read_latency_reg)) |-> ##4 wr_beat_v)
		else $error("write data not sampled one clock before read latency");

	gapless_rd_a: assert property (
		(rd_push && !burst8 && read_latency_reg == 4'h5) ##2 rd_push
		|-> ##3 DQ_OE [*4])
		else $error("gap between back-to-back read bursts");

	long_rd_a: assert property (
		(rd_push && burst8 && read_latency_reg == 4'h5 && $stable(read_latency_reg))
		##1 (!rd_push) [*4] |-> ##1 DQ_OE [*4] ##1 !DQ_OE)
		else $error("long read burst not four clocks");

	gapless_wr_a: assert property (
		(wr_push && !burst8 && read_latency_reg == 4'h5) ##2 wr_push
		|-> ##2 wr_beat_v [*4])
		else $error("gap between back-to-back write bursts");

	closed_bank_a: assert property (
		((is_rd || is_wr) && !bank_ok) |=> err_reg[sbsrt_pkg::ERR_IDLE_BANK])
		else $error("column command to closed bank not flagged");

	sr_open_a: assert property (
		(sr_entry && bank_reg != 8'h00) |=> (SELFREF_ACTIVE && err_reg[sbsrt_pkg::ERR_SR_OPEN]))
		else $error("self-refresh entry with open bank not flagged");

	early_read_a: assert property (
		sr_exit ##1 is_rd |=> err_reg[sbsrt_pkg::ERR_RD_EARLY])
		else $error("read right after self-refresh exit not flagged");
endmodule : sbsrt_top

// ===== sim/sbsrt_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory controller model
// ----------------------------------------
module sbsrt_ctrl_model (
	input wire logic clk,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic [12:0] addr,
	output logic term_en,
	output logic [31:0] dq_in
);
	int cyc = 0;
	logic [31:0] wq[int];
	initial
	begin
		cke = 1'b1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'b111;
		ba = 3'h0;
		addr = 13'h0;
		term_en = 1'b1;
		dq_in = 32'h0;
	end
	// Outside scheduled cycles the data lines toggle, so stale data never matches
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		dq_in <= wq.exists(cyc + 1) ? wq[cyc + 1] : ~dq_in;
	end
	task automatic issue(input sbsrt_pkg::sbsrt_cmd_t op, input logic [2:0] b,
		input logic [12:0] a, output int c);
		@(posedge clk);
		cs_n <= 1'b0;
		{ras_n, cas_n, we_n} <= op;
		ba <= b;
		addr <= a;
		c = cyc + 1;
		@(posedge clk);
		cs_n <= 1'b1;
		{ras_n, cas_n, we_n} <= 3'b111;
	endtask : issue
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	// Bad mode leaves termination on and opens bank 0 before entry on purpose
	task automatic sr_enter(input logic bad);
		int c;
		@(posedge clk);
		if (!bad)
			term_en <= 1'b0;
		issue(bad ? sbsrt_pkg::CMD_ACTIVATE : sbsrt_pkg::CMD_PRECHARGE, 3'h0,
			bad ? 13'h0000 : 13'h0400, c);
		idle(sbsrt_pkg::TERM_OFF_CLK);
		@(posedge clk);
		cke <= 1'b0;
		cs_n <= 1'b0;
		{ras_n, cas_n, we_n} <= sbsrt_pkg::CMD_REFRESH;
		@(posedge clk);
		cs_n <= 1'b1;
		{ras_n, cas_n, we_n} <= 3'b111;
	endtask : sr_enter
	// Early mode turns termination on, reads closed bank 1 and opens bank 0 too soon
	task automatic sr_exit(input logic early);
		int c;
		@(posedge clk);
		cke <= 1'b1;
		if (early)
		begin
			term_en <= 1'b1;
			issue(sbsrt_pkg::CMD_READ, 3'h1, 13'h0, c);
			issue(sbsrt_pkg::CMD_ACTIVATE, 3'h0, 13'h0, c);
		end
		idle(sbsrt_pkg::SELFREF_EXIT_TO_READ_CLK);
		@(posedge clk);
		term_en <= 1'b1;
	endtask : sr_exit
endmodule : sbsrt_ctrl_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic [3:0] AV_ADDRESS = 4'h0;
	logic AV_READ = 1'b0;
	logic AV_WRITE = 1'b0;
	logic [31:0] AV_WRITEDATA = 32'h0;
	logic [3:0] AV_BYTEENABLE = 4'h0;
	logic [31:0] AV_READDATA;
	logic AV_WAITREQUEST;
	logic CKE, CS_N, RAS_N, CAS_N, WE_N, TERMINATION_ENABLE, DQ_OE, TERM_ACTIVE, SELFREF_ACTIVE;
	logic [2:0] BA;
	logic [12:0] ADDR;
	logic [31:0] DQ_IN, DQ_OUT;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [31:0] bus_q;
	integer seed = 32'hEF02F928;
	logic [31:0] mem[128];
	logic [31:0] exp_rd[int];
	logic [7:0] open_banks = 8'h0;
	int rl = 5;
	int wl = 4;
	int nw = 2;
	logic [6:0] cfg_tab[3] = '{7'h7E, 7'h00, 7'h07};
	always #25 MCLK = ~MCLK;
	sbsrt_top sbsrt_top_i (.MCLK(MCLK), .RST(RST), .AV_ADDRESS(AV_ADDRESS), .AV_READ(AV_READ),
		.AV_WRITE(AV_WRITE), .AV_WRITEDATA(AV_WRITEDATA), .AV_BYTEENABLE(AV_BYTEENABLE),
		.AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST), .CKE(CKE), .CS_N(CS_N),
		.RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR),
		.TERMINATION_ENABLE(TERMINATION_ENABLE), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
		.TERM_ACTIVE(TERM_ACTIVE), .SELFREF_ACTIVE(SELFREF_ACTIVE));
	sbsrt_ctrl_model sbsrt_ctrl_model_i (.clk(MCLK), .cke(CKE), .cs_n(CS_N), .ras_n(RAS_N),
		.cas_n(CAS_N), .we_n(WE_N), .ba(BA), .addr(ADDR), .term_en(TERMINATION_ENABLE),
		.dq_in(DQ_IN));
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic finish_test();
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t reg got=%h exp=%h", $time, got, exp);
		end
	endtask : check_reg
	task automatic check_dq(input logic oe, input logic [31:0] got, input logic [32:0] exp);
		n_checks++;
		if ({oe, got} !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t dq got=%h exp=%h", $time, {oe, got}, exp);
		end
	endtask : check_dq
	task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge MCLK);
		AV_ADDRESS <= a;
		AV_WRITEDATA <= d;
		AV_BYTEENABLE <= be;
		AV_WRITE <= wr;
		AV_READ <= !wr;
		do @(posedge MCLK); while (AV_WAITREQUEST !== 1'b0);
		q = AV_READDATA;
		AV_READ <= 1'b0;
		AV_WRITE <= 1'b0;
	endtask : av_xfer
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		av_xfer(1'b0, a, 32'h0, 4'hF, q);
		check_reg(q, exp);
	endtask : rd_reg
	task automatic chk_status(input logic sr);
		rd_reg(sbsrt_pkg::ADDR_STATUS, {15'h0, sr, 4'(wl), 4'(rl), open_banks});
	endtask : chk_status
	// Clamping is modelled here, so only byte lane 0 updates the model
	task automatic set_cfg(input logic [6:0] v, input logic [3:0] be);
		logic [31:0] q;
		int col, add;
		av_xfer(1'b1, sbsrt_pkg::ADDR_CONFIG, {25'h0, v}, be, q);
		if (be[0])
		begin
			col = v[3:1];
			add = v[6:4];
			if (col < sbsrt_pkg::CAL_MIN) col = sbsrt_pkg::CAL_MIN;
			if (col > sbsrt_pkg::CAL_MAX) col = sbsrt_pkg::CAL_MAX;
			if (add > sbsrt_pkg::ADL_MAX) add = sbsrt_pkg::ADL_MAX;
			rl = add + col;
			wl = rl - 1;
			nw = v[0] ? 4 : 2;
		end
	endtask : set_cfg
	// ----------------------------------------
	// Command and burst tasks
	// ----------------------------------------
	function automatic int widx(input int b, input int col, input int i);
		return b * 16 + ((col & ~(nw - 1)) | ((col + i) & (nw - 1)));
	endfunction : widx
	task automatic act(input logic [2:0] b);
		int c;
		sbsrt_ctrl_model_i.issue(sbsrt_pkg::CMD_ACTIVATE, b, 13'h0, c);
		open_banks[b] = 1'b1;
	endtask : act
	task automatic burst(input logic wr, input logic [2:0] b, input logic [3:0] col);
		int c;
		logic [31:0] d;
		sbsrt_ctrl_model_i.issue(wr ? sbsrt_pkg::CMD_WRITE : sbsrt_pkg::CMD_READ, b, {9'h0, col}, c);
		for (int i = 0; i < nw && open_banks[b]; i++)
		begin
			if (wr)
			begin
				d = $random(seed);
				sbsrt_ctrl_model_i.wq[c + wl + i] = d;
				mem[widx(b, col, i)] = d;
			end
			else
				exp_rd[c + rl + i] = mem[widx(b, col, i)];
		end
		sbsrt_ctrl_model_i.idle(nw - 2);
	endtask : burst
	always @(negedge MCLK)
	begin
		if (!RST && exp_rd.exists(sbsrt_ctrl_model_i.cyc))
			check_dq(DQ_OE, DQ_OUT, {1'b1, exp_rd[sbsrt_ctrl_model_i.cyc]});
		else if (!RST)
			check_dq(DQ_OE, DQ_OUT, 33'h0);
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge MCLK);
		RST <= 1'b0;
		repeat (2) @(posedge MCLK);
		chk_status(1'b0);
		rd_reg(4'hC, sbsrt_pkg::UNMAPPED_DATA);
		act(3'h0);
		act(3'h3);
		for (int p = 0; p < 3; p++)
		begin
			for (int k = 0; k < 4; k++) burst(1'b1, (k % 2) ? 3'h3 : 3'h0, 4'(k * 4 + 1));
			sbsrt_ctrl_model_i.idle(6);
			for (int k = 0; k < 4; k++) burst(1'b0, (k % 2) ? 3'h3 : 3'h0, 4'(k * 4 + 1));
			sbsrt_ctrl_model_i.idle(12);
			set_cfg((p == 0) ? 7'h27 : 7'h07, 4'h1);
			chk_status(1'b0);
		end
		burst(1'b0, 3'h5, 4'h0);
		sbsrt_ctrl_model_i.idle(8);
		rd_reg(sbsrt_pkg::ADDR_ERROR, 32'h1 << sbsrt_pkg::ERR_IDLE_BANK);
		set_cfg(7'h3F, 4'h0);
		foreach (cfg_tab[i])
		begin
			set_cfg(cfg_tab[i], 4'h0);
			chk_status(1'b0);
			set_cfg(cfg_tab[i], 4'h1);
			chk_status(1'b0);
		end
		set_cfg(7'h26, 4'h1);
		av_xfer(1'b1, sbsrt_pkg::ADDR_ERROR, 32'h3F, 4'h1, bus_q);
		rd_reg(sbsrt_pkg::ADDR_ERROR, 32'h0);
		sbsrt_ctrl_model_i.sr_enter(1'b0);
		open_banks = 8'h0;
		chk_status(1'b1);
		check_reg({30'h0, SELFREF_ACTIVE, TERM_ACTIVE}, 32'h2);
		sbsrt_ctrl_model_i.sr_exit(1'b0);
		rd_reg(sbsrt_pkg::ADDR_ERROR, 32'h0);
		check_reg({30'h0, SELFREF_ACTIVE, TERM_ACTIVE}, 32'h1);
		sbsrt_ctrl_model_i.sr_enter(1'b1);
		sbsrt_ctrl_model_i.sr_exit(1'b1);
		open_banks[0] = 1'b1;
		rd_reg(sbsrt_pkg::ADDR_ERROR, 32'h3F);
		chk_status(1'b0);
		finish_test();
	end
	initial
	begin
		repeat (30000) @(posedge MCLK);
		n_mismatch++;
		finish_test();
	end
endmodule : testbench
